// ===== hdl/rx_bit_align_collision_capture.v
// Behaviour
// R01: bit 7 clear: bits received after a collision are stored as zero
// R02: first bit stored at first-bit position field, later bits at next positions
// R03: past bit 7 storing continues at bit 0 of the next byte
// R04: first-bit position zero means byte-oriented, non-zero bit-oriented
// R05: bit 3 set: any collision is reported as an integrity error
// R06: bits 2..0 hold valid bits of last byte; zero means all eight
// R07: decoder clears last-bit count at start, loads it at bit-oriented end
// R08: collision valid flag set only when captured position is in range
// R09: bits 6..0 hold zero-based data bit index of the first collision
// R10: only first 8 bytes reportable, highest index 3fh
// R11: non-zero first-bit position is added into the collision index
// R12: software uses position only when valid and in suitable protocol modes
// R13: collision raises collision flag and captures position; cleared at start
// R14: a collision inside the end-of-frame symbol raises no flag
// R15: collision valid flag and position cleared at each reception start
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_defs.vh"
module rx_bit_align_collision_capture #(
   parameter COUNT_WIDTH = 10
) (
   // clock, reset, enable
   input wire I_CORE_CLK,
   input wire I_SYS_RST,
   input wire I_CE,
   // ahb-lite slave
   input wire I_HSEL,
   input wire [7:0] I_HADDR,
   input wire [1:0] I_HTRANS,
   input wire I_HWRITE,
   input wire [2:0] I_HSIZE,
   input wire I_HREADY,
   input wire [31:0] I_HWDATA,
   output reg [31:0] O_HRDATA,
   output reg O_HREADYOUT,
   output reg O_HRESP,
   // bit stream from the receive decoder
   input wire I_RX_START,
   input wire I_RX_BIT_VALID,
   input wire I_RX_BIT,
   input wire I_RX_BIT_COLL,
   input wire I_RX_BIT_EOF,
   input wire I_RX_END,
   // assembled bytes and flags
   output reg O_BYTE_VALID,
   output reg [7:0] O_BYTE_DATA,
   output reg O_BYTE_LAST,
   output reg O_COLLISION_DETECTED,
   output reg O_INTEGRITY_ERROR,
   output reg O_IRQ
);

   // ********************************
   // register state
   // ********************************
   reg keep_bits_after_collision_reg;
   reg [2:0] rx_first_bit_position_reg;
   reg collision_as_integrity_error_reg;
   reg [2:0] rx_final_byte_valid_bits_reg;
   reg collision_position_valid_reg;
   reg [6:0] collision_bit_position_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_enable_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;

   // ********************************
   // receive state
   // ********************************
   reg [7:0] acc_reg;
   reg [2:0] bit_pos_reg;
   reg coll_seen_reg;
   reg [COUNT_WIDTH-1:0] bit_count_reg;

   wire addr_phase;
   wire data_bit;
   wire new_coll;
   wire stored_bit;
   wire [COUNT_WIDTH-1:0] coll_index;
   wire [7:0] acc_with_bit;
   wire [2:0] evt_set;
   wire [2:0] irq_status_next;
   wire wr_ctrl;
   wire wr_clear;
   wire [7:0] ctrl_rst_value;

   // reset fields are taken from one word so the header holds a single value
   assign ctrl_rst_value = `BIT_CONTROL_RST;

   function [31:0] read_mux;
      input [7:0] addr;
      begin
         case (addr)
            `ADDR_BIT_CONTROL: read_mux = {24'h000000, keep_bits_after_collision_reg,
               rx_first_bit_position_reg, collision_as_integrity_error_reg,
               rx_final_byte_valid_bits_reg};
            `ADDR_COLL_INFO: read_mux = {24'h000000, collision_position_valid_reg,
               collision_bit_position_reg};
            `ADDR_IRQ_STATUS: read_mux = {29'h0, irq_status_reg};
            `ADDR_IRQ_ENABLE: read_mux = {29'h0, irq_enable_reg};
            default: read_mux = 32'h00000000;
         endcase
      end
   endfunction

   // ********************************
   // bus decode
   // ********************************
   // the slave never stalls, so a read is answered in the data phase
   assign addr_phase = I_HSEL & I_HTRANS[1] & I_HREADY;
   assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `ADDR_BIT_CONTROL);
   assign wr_clear = wr_pend_reg & (wr_addr_reg == `ADDR_IRQ_CLEAR);

   // ********************************
   // bit placement
   // ********************************
   // end-of-frame bits carry no data and never count as collisions
   assign data_bit = I_RX_BIT_VALID & ~I_RX_BIT_EOF & ~I_RX_START;
   assign new_coll = data_bit & I_RX_BIT_COLL & ~coll_seen_reg; // R14
   assign stored_bit = (coll_seen_reg & ~keep_bits_after_collision_reg) ? 1'b0 : I_RX_BIT; // R01
   assign acc_with_bit = acc_reg | ({7'h00, stored_bit} << bit_pos_reg); // R02
   assign coll_index = bit_count_reg + {{(COUNT_WIDTH-3){1'b0}}, rx_first_bit_position_reg}; // R11
   assign evt_set = {I_RX_END & ~I_RX_START, new_coll & collision_as_integrity_error_reg,
      new_coll};
   assign irq_status_next = (irq_status_reg & ~(wr_clear ? I_HWDATA[2:0] : 3'h0)) | evt_set;

   // ********************************
   // bus slave
   // ********************************
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_HRDATA <= 32'h00000000;
         O_HREADYOUT <= 1'b0;
         O_HRESP <= 1'b0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         irq_enable_reg <= `IRQ_RST;
         irq_status_reg <= `IRQ_RST;
         O_IRQ <= 1'b0;
      end else if (I_CE) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         wr_pend_reg <= addr_phase & I_HWRITE;
         wr_addr_reg <= {I_HADDR[7:2], 2'b00};
         if (addr_phase & ~I_HWRITE) begin
            O_HRDATA <= read_mux({I_HADDR[7:2], 2'b00});
         end
         if (wr_pend_reg & (wr_addr_reg == `ADDR_IRQ_ENABLE)) begin
            irq_enable_reg <= I_HWDATA[2:0];
         end
         // a new event wins over a clear in the same cycle
         irq_status_reg <= irq_status_next;
         O_IRQ <= |(irq_status_next & irq_enable_reg);
      end
   end

   // ********************************
   // control register and receive path
   // ********************************
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         keep_bits_after_collision_reg <= ctrl_rst_value[`KEEP_AFTER_COLL_BIT];
         rx_first_bit_position_reg <= ctrl_rst_value[`FIRST_POS_HI:`FIRST_POS_LO];
         collision_as_integrity_error_reg <= ctrl_rst_value[`COLL_AS_INTEG_BIT];
         rx_final_byte_valid_bits_reg <= ctrl_rst_value[`LAST_BITS_HI:`LAST_BITS_LO];
         collision_position_valid_reg <= 1'b0;
         collision_bit_position_reg <= 7'h00;
         acc_reg <= 8'h00;
         bit_pos_reg <= 3'h0;
         coll_seen_reg <= 1'b0;
         bit_count_reg <= {COUNT_WIDTH{1'b0}};
         O_BYTE_VALID <= 1'b0;
         O_BYTE_DATA <= 8'h00;
         O_BYTE_LAST <= 1'b0;
         O_COLLISION_DETECTED <= 1'b0;
         O_INTEGRITY_ERROR <= 1'b0;
      end else if (I_CE) begin
         O_BYTE_VALID <= 1'b0;
         O_BYTE_LAST <= 1'b0;
         if (wr_ctrl) begin
            keep_bits_after_collision_reg <= I_HWDATA[`KEEP_AFTER_COLL_BIT];
            rx_first_bit_position_reg <= I_HWDATA[`FIRST_POS_HI:`FIRST_POS_LO];
            collision_as_integrity_error_reg <= I_HWDATA[`COLL_AS_INTEG_BIT];
            rx_final_byte_valid_bits_reg <= I_HWDATA[`LAST_BITS_HI:`LAST_BITS_LO];
         end
         if (I_RX_START) begin
            // a start overrides a bit or an end in the same cycle
            rx_final_byte_valid_bits_reg <= 3'h0; // R07
            collision_position_valid_reg <= 1'b0; // R15
            collision_bit_position_reg <= 7'h00; // R15
            O_COLLISION_DETECTED <= 1'b0; // R13
            O_INTEGRITY_ERROR <= 1'b0;
            coll_seen_reg <= 1'b0;
            acc_reg <= 8'h00;
            bit_pos_reg <= rx_first_bit_position_reg; // R02
            bit_count_reg <= {COUNT_WIDTH{1'b0}};
         end else begin
            if (data_bit) begin
               if (bit_count_reg != {COUNT_WIDTH{1'b1}}) begin
                  bit_count_reg <= bit_count_reg + 1'b1;
               end
               if (bit_pos_reg == 3'h7) begin
                  // byte full: next bit goes to bit 0 of the next byte
                  O_BYTE_VALID <= 1'b1; // R03
                  O_BYTE_DATA <= acc_with_bit;
                  acc_reg <= 8'h00;
                  bit_pos_reg <= 3'h0; // R03
               end else begin
                  acc_reg <= acc_with_bit;
                  bit_pos_reg <= bit_pos_reg + 3'h1; // R02
               end
            end
            if (new_coll) begin
               coll_seen_reg <= 1'b1;
               O_COLLISION_DETECTED <= 1'b1; // R13
               if (collision_as_integrity_error_reg) begin
                  O_INTEGRITY_ERROR <= 1'b1; // R05
               end
               // positions past the eighth byte cannot be shown
               if (coll_index <= `COLL_POS_MAX) begin
                  collision_position_valid_reg <= 1'b1; // R08
                  collision_bit_position_reg <= coll_index[6:0]; // R09
               end // R10
            end
            if (I_RX_END & ~data_bit) begin
               // partial byte flushed; a full byte was already sent
               if (bit_pos_reg != 3'h0) begin
                  O_BYTE_VALID <= 1'b1;
                  O_BYTE_DATA <= acc_reg;
               end
               O_BYTE_LAST <= 1'b1;
               if (rx_first_bit_position_reg != 3'h0) begin
                  rx_final_byte_valid_bits_reg <= bit_pos_reg; // R04 R06 R07
               end
            end
         end
      end
   end

endmodule // rx_bit_align_collision_capture
`default_nettype wire

// ===== hdl/rx_align_defs.vh
`ifndef RX_ALIGN_DEFS_VH
`define RX_ALIGN_DEFS_VH
// ********************************
// register byte addresses
// ********************************
`define ADDR_BIT_CONTROL 8'h0c
`define ADDR_COLL_INFO 8'h10
`define ADDR_IRQ_STATUS 8'h14
`define ADDR_IRQ_CLEAR 8'h18
`define ADDR_IRQ_ENABLE 8'h1c
// ********************************
// field positions
// ********************************
`define KEEP_AFTER_COLL_BIT 7
`define FIRST_POS_HI 6
`define FIRST_POS_LO 4
`define COLL_AS_INTEG_BIT 3
`define LAST_BITS_HI 2
`define LAST_BITS_LO 0
`define COLL_VALID_BIT 7
`define COLL_POS_HI 6
`define COLL_POS_LO 0
`define EVT_COLLISION 0
`define EVT_INTEGRITY 1
`define EVT_FRAME_END 2
// ********************************
// reset values and limits
// ********************************
`define BIT_CONTROL_RST 8'h00
`define COLL_INFO_RST 8'h00
`define IRQ_RST 3'h0
`define COLL_POS_MAX 10'h03f
`endif

// ===== verification/rx_align_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rx_align_checker (
   input wire I_CORE_CLK, I_SYS_RST, I_HSEL, I_HREADY,
   input wire [1:0] I_HTRANS,
   input wire I_RX_START, I_RX_BIT_VALID, I_RX_BIT_COLL, I_RX_BIT_EOF, I_RX_END,
   input wire O_HREADYOUT, O_BYTE_VALID, O_BYTE_LAST,
   input wire O_COLLISION_DETECTED, O_INTEGRITY_ERROR
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   property p_coll_cause;
      $rose(O_COLLISION_DETECTED) |->
         $past(I_RX_BIT_VALID & I_RX_BIT_COLL & ~I_RX_BIT_EOF & ~I_RX_START);
   endproperty
   a_coll_cause: assert property (p_coll_cause) else $error("collision flag without cause");
   property p_start_clear;
      I_RX_START |=> !O_COLLISION_DETECTED;
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("flag kept over start");
   property p_coll_hold;
      !I_RX_START & !I_RX_BIT_VALID |=> $stable(O_COLLISION_DETECTED);
   endproperty
   a_coll_hold: assert property (p_coll_hold) else $error("flag moved while idle");
   property p_eof_quiet;
      I_RX_BIT_VALID & I_RX_BIT_EOF & !O_COLLISION_DETECTED |=> !O_COLLISION_DETECTED;
   endproperty
   a_eof_quiet: assert property (p_eof_quiet) else $error("eof collision flagged");
   property p_integ;
      $rose(O_INTEGRITY_ERROR) |-> O_COLLISION_DETECTED;
   endproperty
   a_integ: assert property (p_integ) else $error("integrity error without collision");
   property p_last;
      I_RX_END & !I_RX_BIT_VALID & !I_RX_START |=> O_BYTE_LAST;
   endproperty
   a_last: assert property (p_last) else $error("frame end not marked");
   property p_byte;
      O_BYTE_VALID |-> $past(I_RX_BIT_VALID) | O_BYTE_LAST;
   endproperty
   a_byte: assert property (p_byte) else $error("byte without a bit");
   property p_ready;
      I_HSEL & I_HTRANS[1] & I_HREADY |=> O_HREADYOUT [*2];
   endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule // rx_align_checker
`default_nettype wire

// ===== verification/card_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_model (
   input wire logic i_clk,
   output logic o_start, o_valid, o_bit, o_coll, o_eof, o_end
);
   initial {o_start, o_valid, o_bit, o_coll, o_eof, o_end} = 6'h00;
   // n data bits, collision at index c, then a colliding eof symbol bit
   task automatic frame(input int n, input logic [79:0] d, input int c);
      @(posedge i_clk) o_start <= 1'b1;
      @(posedge i_clk) o_start <= 1'b0;
      for (int i = 0; i <= n; i++) begin
         o_valid <= 1'b1;
         o_bit <= (i < n) ? d[i] : 1'b1;
         o_coll <= (i == c) || (i == n);
         o_eof <= (i == n);
         @(posedge i_clk);
      end
      // released data line shows the inverse, never a stale level
      o_bit <= ~o_bit;
      o_valid <= 1'b0;
      o_coll <= 1'b0;
      o_eof <= 1'b0;
      o_end <= 1'b1;
      @(posedge i_clk) o_end <= 1'b0;
   endtask
endmodule // card_model
`default_nettype wire

// ===== verification/rx_bit_align_collision_capture_test.sv
`timescale 1ns/1ps
`default_nettype none
module rx_bit_align_collision_capture_test;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, rd;
   wire [31:0] hrdata;
   wire [7:0] bdata;
   wire hready, hresp, st, bv, bt, co, eo, en, bval, blast, cdet, integ, irq;
   logic [7:0] bytes[$];
   int miscompares = 0, comparisons = 0, cycles = 0, lasts = 0;
   always #25 clk = ~clk;
   card_model i_card (.i_clk(clk), .o_start(st), .o_valid(bv), .o_bit(bt),
      .o_coll(co), .o_eof(eo), .o_end(en));
   rx_bit_align_collision_capture i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HREADY(hready), .I_HWDATA(hwdata), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .I_RX_START(st), .I_RX_BIT_VALID(bv),
      .I_RX_BIT(bt), .I_RX_BIT_COLL(co), .I_RX_BIT_EOF(eo), .I_RX_END(en),
      .O_BYTE_VALID(bval), .O_BYTE_DATA(bdata), .O_BYTE_LAST(blast),
      .O_COLLISION_DETECTED(cdet), .O_INTEGRITY_ERROR(integ), .O_IRQ(irq));
   always @(posedge clk) begin
      if (bval === 1'b1)
         bytes.push_back(bdata);
      if (blast === 1'b1)
         lasts++;
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single word transfer; waits on the slave, the cycle ceiling ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk(hresp, 0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, 8'h0c, 0);
      chk(rd, 0);
      bus(1, 8'h10, 32'hff);
      bus(0, 8'h10, 0);
      chk(rd, 0);
      bus(0, 8'h40, 0);
      chk(rd, 0);
      bus(1, 8'h1c, 1);
      for (int k = 0; k < 2; k++) begin
         bus(1, 8'h0c, k ? 32'hc8 : 32'h40);
         bytes.delete();
         i_card.frame(5, 80'h1d, 3);
         bus(0, 8'h0c, 0);
         chk(rd, k ? 32'hc9 : 32'h41);
         bus(0, 8'h10, 0);
         chk(rd, 32'h87);
         chk(bytes.size(), 2);
         chk(bytes[0], 8'hd0);
         chk(bytes[1], k);
         chk(integ, k);
         chk(irq, 1);
         bus(1, 8'h18, 7);
         bus(0, 8'h14, 0);
         chk(rd, 0);
         chk(irq, 0);
      end
      bus(1, 8'h0c, 0);
      bytes.delete();
      i_card.frame(8, 80'ha5, -1);
      bus(0, 8'h10, 0);
      chk(rd, 0);
      bus(0, 8'h0c, 0);
      chk(rd, 0);
      chk(bytes.size(), 1);
      chk(bytes[0], 8'ha5);
      chk(cdet, 0);
      chk(lasts, 3);
      for (int k = 63; k < 65; k++) begin
         i_card.frame(k + 1, 0, k);
         bus(0, 8'h10, 0);
         chk(rd, k < 64 ? 32'hbf : 0);
         chk(cdet, 1);
      end
      close_out();
   end
endmodule // rx_bit_align_collision_capture_test
bind rx_bit_align_collision_capture rx_align_checker i_chk (.*);
`default_nettype wire
